// ### rtl/asr_host.sv
// host controller driving the 16k x 1 static memory over its pins
`timescale 1ns/10ps
module asr_host #(
  parameter int ADDR_W = asr_pkg::ADDR_W
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [ADDR_W-1:0] i_req_addr,
  input wire logic i_req_wdata,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output logic o_rsp_rdata,
  output logic [ADDR_W-1:0] o_word_select,
  output logic o_chip_en_n,
  output logic o_write_en_n,
  output logic o_data_in,
  input wire logic i_data_out,
  output logic o_powered_down
);
  // a phase count the timer cannot hold would wrap and cut the phase short
  if (ADDR_W != asr_pkg::ADDR_W) begin : g_bad_addr_w
    $error("address width must match the memory");
  end
  if (asr_pkg::SETUP_CYC < 1 || asr_pkg::STROBE_CYC < 1 ||
      asr_pkg::ACCESS_CYC < 1 || asr_pkg::RECOVER_CYC < 1) begin : g_bad_phase
    $error("every bus phase needs at least one cycle");
  end
  if (asr_pkg::SETUP_CYC > (1 << asr_pkg::CNT_W)) begin : g_bad_setup
    $error("setup count does not fit the phase timer");
  end
  if (asr_pkg::STROBE_CYC > (1 << asr_pkg::CNT_W)) begin : g_bad_strobe
    $error("strobe count does not fit the phase timer");
  end
  if (asr_pkg::ACCESS_CYC > (1 << asr_pkg::CNT_W)) begin : g_bad_access
    $error("access count does not fit the phase timer");
  end
  if (asr_pkg::RECOVER_CYC > (1 << asr_pkg::CNT_W)) begin : g_bad_recover
    $error("recover count does not fit the phase timer");
  end

  asr_pkg::asr_state_t state_q;
  logic write_q;
  logic take;
  logic read_end;
  logic chip_sel_d;
  logic write_sel_d;
  logic load;
  logic [asr_pkg::CNT_W-1:0] load_cnt;
  logic done;

  assign o_req_ready = (state_q == asr_pkg::ASR_IDLE);
  assign take = o_req_ready && i_req_valid;
  assign read_end = (state_q == asr_pkg::ASR_ACCESS) && done;

  always_comb begin
    load = 1'b0;
    load_cnt = '0;
    case (state_q)
      asr_pkg::ASR_IDLE: begin
        load = i_req_valid;
        load_cnt = asr_pkg::CNT_W'(asr_pkg::SETUP_CYC - 1);
      end
      asr_pkg::ASR_SETUP: begin
        load = done;
        load_cnt = write_q ? asr_pkg::CNT_W'(asr_pkg::STROBE_CYC - 1)
                           : asr_pkg::CNT_W'(asr_pkg::ACCESS_CYC - 1);
      end
      asr_pkg::ASR_STROBE, asr_pkg::ASR_ACCESS: begin
        load = done;
        load_cnt = asr_pkg::CNT_W'(asr_pkg::RECOVER_CYC - 1);
      end
      default: begin
        load = 1'b0;
        load_cnt = '0;
      end
    endcase
  end

  // one shared timer: phases never overlap, so one counter serves them all
  asr_phase_timer #(
    .WIDTH(asr_pkg::CNT_W)
  ) u_timer (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_load(load),
    .i_count(load_cnt),
    .o_done(done)
  );

  // phases run strictly in order; a request is only taken in idle
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= asr_pkg::ASR_IDLE;
    end else begin
      case (state_q)
        asr_pkg::ASR_IDLE: begin
          if (i_req_valid) begin
            state_q <= asr_pkg::ASR_SETUP;
          end
        end
        asr_pkg::ASR_SETUP: begin
          if (done) begin
            state_q <= write_q ? asr_pkg::ASR_STROBE : asr_pkg::ASR_ACCESS;
          end
        end
        asr_pkg::ASR_STROBE, asr_pkg::ASR_ACCESS: begin
          if (done) begin
            state_q <= asr_pkg::ASR_RECOVER;
          end
        end
        asr_pkg::ASR_RECOVER: begin
          if (done) begin
            state_q <= asr_pkg::ASR_IDLE;
          end
        end
        default: begin
          state_q <= asr_pkg::ASR_IDLE;
        end
      endcase
    end
  end

  // kind of access, held until the next request is taken
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      write_q <= 1'b0;
    end else if (take) begin
      write_q <= i_req_write;
    end
  end

  // pins launch at the take, a full setup phase before chip select falls,
  // so no enable edge ever shares a clock edge with an address change
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_word_select <= '0;
      o_data_in <= 1'b0;
    end else if (take) begin
      o_word_select <= i_req_addr;
      o_data_in <= i_req_wdata;
    end
  end

  // in a write both enables fall together and rise together: write is the overlap; in a read write enable stays high
  always_comb begin
    chip_sel_d = 1'b0;
    write_sel_d = 1'b0;
    case (state_q)
      asr_pkg::ASR_SETUP: begin
        chip_sel_d = done;
        write_sel_d = done && write_q;
      end
      asr_pkg::ASR_STROBE: begin
        chip_sel_d = !done;
        write_sel_d = !done;
      end
      asr_pkg::ASR_ACCESS: begin
        chip_sel_d = !done;
        write_sel_d = 1'b0;
      end
      default: begin
        chip_sel_d = 1'b0;
        write_sel_d = 1'b0;
      end
    endcase
  end

  // chip select high outside an access keeps the memory powered down
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_chip_en_n <= 1'b1;
    end else begin
      o_chip_en_n <= !chip_sel_d;
    end
  end

  // strobe never falls in a read; in a write it rises on the same edge as select
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_write_en_n <= 1'b1;
    end else begin
      o_write_en_n <= !write_sel_d;
    end
  end

  // sample at end of access; full chip-select time always waited, since
  // whether the memory stayed selected cannot be relied on between requests
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rsp_valid <= 1'b0;
    end else begin
      o_rsp_valid <= read_end;
    end
  end

  // read bit holds until the next read completes
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rsp_rdata <= 1'b0;
    end else if (read_end) begin
      o_rsp_rdata <= i_data_out;
    end
  end

  // status mirrors the registered select, so it never glitches
  assign o_powered_down = o_chip_en_n;
endmodule

// ### shared/asr_pkg.sv
// constants for the host-side controller of the 16k x 1 static memory
package asr_pkg;
  localparam int ADDR_W = 14;
  localparam int CLK_PERIOD_NS = 50;
  // bus-phase times in ns, as chosen for the slowest speed grade
  localparam int T_SETUP_NS = 50;
  localparam int T_STROBE_NS = 70;
  localparam int T_ACCESS_NS = 80;
  localparam int T_RECOVER_NS = 50;
  // least times round up to whole cycles, never below one
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  typedef enum logic [2:0] {
    ASR_IDLE,
    ASR_SETUP,
    ASR_STROBE,
    ASR_ACCESS,
    ASR_RECOVER
  } asr_state_t;
endpackage

// ### rtl/asr_phase_timer.sv
// down-counter that times one bus phase
`timescale 1ns/10ps
module asr_phase_timer #(
  parameter int WIDTH = 4
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_count,
  output logic o_done
);
  logic [WIDTH-1:0] cnt_q;

  if (WIDTH < 1) begin : g_bad_width
    $error("phase timer needs at least one bit");
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else if (i_load) begin
      cnt_q <= i_count;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // count alone: the controller may load in the same cycle that it sees done
  assign o_done = (cnt_q == '0);
endmodule

// ### sim/asr_host_sva.sv
// pin protocol checks for the memory host
`timescale 1ns/10ps
module asr_host_sva (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic o_rsp_valid,
  input wire logic o_rsp_rdata,
  input wire logic [13:0] o_word_select,
  input wire logic o_chip_en_n,
  input wire logic o_write_en_n,
  input wire logic o_data_in,
  input wire logic i_data_out
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  chk_addr_held: assert property (
    !o_chip_en_n && !$fell(o_chip_en_n) |-> $stable(o_word_select)) else $error("addr moved");
  chk_read_we_high: assert property (
    $fell(o_chip_en_n) && o_write_en_n |-> o_write_en_n[*3]) else $error("strobe in read");
  chk_data_held: assert property (
    !o_write_en_n |=> $stable(o_data_in)) else $error("data moved");
  chk_end_both: assert property (
    $rose(o_write_en_n) |-> $rose(o_chip_en_n)) else $error("split end");
  chk_strobe_len: assert property (
    $fell(o_write_en_n) |-> $fell(o_chip_en_n) ##1 !o_write_en_n ##1 o_write_en_n)
    else $error("strobe length");
  chk_read_data: assert property (
    $fell(o_chip_en_n) && o_write_en_n |-> ##2 o_rsp_valid && o_rsp_rdata == $past(i_data_out))
    else $error("read answer");
endmodule
bind asr_host asr_host_sva chk_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
  .o_rsp_valid(o_rsp_valid), .o_rsp_rdata(o_rsp_rdata), .o_word_select(o_word_select),
  .o_chip_en_n(o_chip_en_n), .o_write_en_n(o_write_en_n), .o_data_in(o_data_in),
  .i_data_out(i_data_out));

// ### sim/asr_mem_model.sv
// behavioural 16k x 1 static memory
`timescale 1ns/10ps
module asr_mem_model (
  input wire logic [13:0] i_word_select,
  input wire logic i_chip_en_n,
  input wire logic i_write_en_n,
  input wire logic i_data_in,
  output logic o_data_out
);
  logic mem [16384];
  logic last_q;
  wire drive = !i_chip_en_n && i_write_en_n;
  always @* begin
    if (!i_chip_en_n && !i_write_en_n) mem[i_word_select] = i_data_in;
    if (drive) last_q = mem[i_word_select];
  end
  // floating pin reads back the last driven bit inverted, which can still match a different cell
  assign o_data_out = drive ? mem[i_word_select] : ~last_q;
endmodule

// ### sim/testbench.sv
// bench for the memory host controller
`timescale 1ns/10ps
module testbench;
  logic clk, rst_n, vld, wr, wd, rdy, rv, rd, ce_n, we_n, din, dout, pd;
  logic [13:0] a, ws;
  int num_errors, samples_checked;
  asr_host dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_req_valid(vld), .i_req_write(wr),
    .i_req_addr(a), .i_req_wdata(wd), .o_req_ready(rdy), .o_rsp_valid(rv), .o_rsp_rdata(rd),
    .o_word_select(ws), .o_chip_en_n(ce_n), .o_write_en_n(we_n), .o_data_in(din),
    .i_data_out(dout), .o_powered_down(pd));
  asr_mem_model mem (.i_word_select(ws), .i_chip_en_n(ce_n), .i_write_en_n(we_n),
    .i_data_in(din), .o_data_out(dout));
  task automatic chk(string n, logic e, logic s);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %b seen %b", n, e, s);
    end
  endtask
  task automatic go(logic w, logic [13:0] ad, logic d);
    int n = 0;
    while (rdy !== 1'b1 && n++ < 20) @(negedge clk);
    chk("request ready", 1'b1, rdy);
    chk("powered down idle", 1'b1, pd);
    vld = 1;
    wr = w;
    a = ad;
    wd = d;
    @(negedge clk);
    vld = 0;
  endtask
  task automatic rchk(logic [13:0] ad, logic e);
    int n = 0;
    go(0, ad, 0);
    @(negedge clk);
    chk("powered down access", 1'b0, pd);
    while (rv !== 1'b1 && n++ < 9) @(negedge clk);
    chk("read valid", 1'b1, rv);
    chk("read bit", e, rd);
    @(negedge clk);
    chk("read valid drop", 1'b0, rv);
  endtask
  task t_bounds;
    go(1, 14'h0000, 1);
    go(1, 14'h3FFF, 0);
    rchk(14'h0000, 1);
    rchk(14'h3FFF, 0);
    $display("bounds done");
  endtask
  task t_rewrite;
    go(1, 14'h2AAA, 0);
    go(1, 14'h2AAA, 1);
    @(negedge clk);
    // pulse while busy, must be ignored
    wd = 0;
    vld = 1;
    @(negedge clk);
    vld = 0;
    rchk(14'h2AAA, 1);
    rchk(14'h2AAA, 1);
    $display("rewrite done");
  endtask
  task close_out;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  initial begin
    #50000;
    num_errors++;
    close_out;
  end
  initial begin
    rst_n = 0;
    vld = 0;
    wr = 0;
    a = 0;
    wd = 0;
    repeat (20) @(negedge clk);
    rst_n = 1;
    t_bounds;
    t_rewrite;
    close_out;
  end
endmodule
